/* File: design/cmu_pkg.sv */
/*
  Constants, register map and carrier types of the counter compare match unit.
  Assumes one 10 MHz clock shared with the counter that feeds the unit.
*/
// What this block does
// - target mode flag actions are configured separately for up and down counting
// - conflicting items resolve by fixed priority, item 0 highest, item 15 lowest
// - an up-count match applies only that item's up-set and up-reset selections
// - a down-count target match applies only that item's down-set and down-reset selections
// - ring counters accept ranges spanning the wrap point and evaluate them correctly
// - one mode select shared by all items, target or band, and a count of active items
// - band mode keeps separate lower and upper limits per item, set independently
// - inside an item's band, selected flags are driven to that item's ON or OFF level
// - sixteen comparison items 0 to 15 and sixteen match flags 0 to 15
// - per item, direction and flag: no change, set, or reset on a target match
package cmu_pkg;
  localparam int CMU_ITEMS = 16;
  localparam int CMU_FLAGS = 16;
  localparam int CMU_CNT_W = 32;
  localparam int CMU_ADDR_W = 10;
  localparam int CMU_DATA_W = 32;
  localparam int CMU_IDX_W = 4;
  localparam int CMU_ACT_W = 5;
  localparam int CMU_FIELD_W = 3;

  localparam logic [CMU_ADDR_W-1:0] CMU_ADDR_CTRL = 10'h000;
  localparam logic [CMU_ADDR_W-1:0] CMU_ADDR_FLAGS = 10'h004;
  localparam logic [CMU_ADDR_W-1:0] CMU_ADDR_STATUS = 10'h008;
  localparam logic [CMU_ADDR_W-1:0] CMU_ADDR_MASK = 10'h00C;
  localparam int CMU_ITEM_SEL_BIT = 9;
  localparam int CMU_ITEM_IDX_LSB = 5;
  localparam int CMU_FIELD_LSB = 2;

  localparam logic [CMU_FIELD_W-1:0] CMU_FLD_LOW = 3'h0;
  localparam logic [CMU_FIELD_W-1:0] CMU_FLD_HIGH = 3'h1;
  localparam logic [CMU_FIELD_W-1:0] CMU_FLD_UP_SET = 3'h2;
  localparam logic [CMU_FIELD_W-1:0] CMU_FLD_UP_RST = 3'h3;
  localparam logic [CMU_FIELD_W-1:0] CMU_FLD_DN_SET = 3'h4;
  localparam logic [CMU_FIELD_W-1:0] CMU_FLD_DN_RST = 3'h5;

  localparam int CMU_CTRL_MODE_BIT = 0;
  localparam int CMU_CTRL_EN_BIT = 1;
  localparam int CMU_CTRL_ACT_LSB = 8;
  localparam logic [CMU_ACT_W-1:0] CMU_ACTIVE_RST = 5'h10;
  localparam logic [CMU_ACT_W-1:0] CMU_ACTIVE_MAX = 5'h10;
  localparam logic [CMU_FLAGS-1:0] CMU_FLAGS_RST = 16'h0000;
  localparam logic [CMU_DATA_W-1:0] CMU_DATA_ZERO = 32'h0000_0000;

  typedef enum logic
  {
    CMU_MODE_TARGET = 1'h0,
    CMU_MODE_BAND = 1'h1
  } cmu_mode_t;

  typedef struct packed
  {
    logic step;
    logic up;
    logic [CMU_CNT_W-1:0] value;
  } cmu_count_t;

  typedef struct packed
  {
    logic [CMU_CNT_W-1:0] low;
    logic [CMU_CNT_W-1:0] high;
    logic [CMU_FLAGS-1:0] up_set;
    logic [CMU_FLAGS-1:0] up_rst;
    logic [CMU_FLAGS-1:0] dn_set;
    logic [CMU_FLAGS-1:0] dn_rst;
  } cmu_item_cfg_t;

  typedef struct packed
  {
    logic [CMU_FLAGS-1:0] set;
    logic [CMU_FLAGS-1:0] clr;
  } cmu_action_t;
endpackage : cmu_pkg

/* File: design/cmu_item.sv */
/*
  One comparison item: target match or band test against the counter value.
  Assumes the count struct comes from logic on the same clock.
*/
`timescale 1ns/1ps
module cmu_item
  import cmu_pkg::*;
(
  input wire cmu_count_t count,
  input wire cmu_item_cfg_t cfg,
  input wire cmu_mode_t mode,
  input wire logic active,
  output cmu_action_t action
);
  logic hit;
  logic wrap;
  logic above_low;
  logic below_high;
  logic in_band;

  assign hit = count.step && (count.value == cfg.low);
  // a lower limit above the upper one means the band spans the rollover point
  assign wrap = $signed(cfg.low) > $signed(cfg.high);
  assign above_low = $signed(count.value) >= $signed(cfg.low);
  assign below_high = $signed(count.value) <= $signed(cfg.high);
  assign in_band = wrap ? (above_low || below_high) : (above_low && below_high);

  always_comb
  begin
    action.set = '0;
    action.clr = '0;
    if (active && mode == CMU_MODE_TARGET && hit)
    begin
      if (count.up)
      begin
        action.set = cfg.up_set;
        action.clr = cfg.up_rst;
      end
      else
      begin
        action.set = cfg.dn_set;
        action.clr = cfg.dn_rst;
      end
    end
    else if (active && mode == CMU_MODE_BAND && in_band)
    begin
      action.set = cfg.up_set;
      action.clr = cfg.up_rst;
    end
  end
endmodule : cmu_item

/* File: design/cmu_irq.sv */
/*
  Sticky status, mask and level interrupt for flag rise events.
  Assumes the status read strobe is the bus read of the status register.
*/
`timescale 1ns/1ps
module cmu_irq
  import cmu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CMU_FLAGS-1:0] events,
  input wire logic status_rd,
  input wire logic mask_wr,
  input wire logic [CMU_FLAGS-1:0] mask_wdata,
  output logic [CMU_FLAGS-1:0] status,
  output logic [CMU_FLAGS-1:0] mask,
  output logic irq
);
  logic [CMU_FLAGS-1:0] status_r;
  logic [CMU_FLAGS-1:0] mask_r;

  // an event in the clearing read cycle survives
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_r <= CMU_FLAGS_RST;
    else if (status_rd)
      status_r <= events;
    else
      status_r <= status_r | events;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= CMU_FLAGS_RST;
    else if (mask_wr)
      mask_r <= mask_wdata;
  end

  assign status = status_r;
  assign mask = mask_r;
  // level straight from the registers, so a clearing read drops it at once
  assign irq = |(status_r & mask_r);
endmodule : cmu_irq

/* File: design/cmu_unit.sv */
/*
  Top of the counter compare match unit: register file, sixteen items,
  priority merge of their actions into sixteen match flags, interrupt.
  Assumes the counter runs on clk and presents each new value with a one-cycle step.
*/
`timescale 1ns/1ps
module cmu_unit
  import cmu_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire cmu_count_t count,
  input wire logic [CMU_ADDR_W-1:0] bus_addr,
  input wire logic [CMU_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [CMU_DATA_W-1:0] bus_rdata,
  output logic [CMU_FLAGS-1:0] match_flags,
  output logic irq
);
  logic [1:0] rst_sync_r;
  logic rst_n;

  cmu_mode_t mode_r;
  logic enable_r;
  logic [CMU_ACT_W-1:0] active_r;
  logic [CMU_ACT_W-1:0] active_nxt;
  cmu_item_cfg_t cfg_r [CMU_ITEMS];

  logic [CMU_FLAGS-1:0] flags_r;
  logic [CMU_FLAGS-1:0] flags_nxt;
  logic [CMU_FLAGS-1:0] merged;
  logic [CMU_FLAGS-1:0] rise;
  logic [CMU_DATA_W-1:0] rdata_r;
  logic [CMU_DATA_W-1:0] rdata_nxt;

  cmu_action_t action [CMU_ITEMS];
  logic [CMU_ITEMS-1:0] item_active;

  logic item_sel;
  logic [CMU_IDX_W-1:0] item_idx;
  logic [CMU_FIELD_W-1:0] field;
  logic status_rd;
  logic mask_wr;
  logic [CMU_FLAGS-1:0] status;
  logic [CMU_FLAGS-1:0] mask;

  // reset is asserted at once and released two edges later
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'h1};
  end

  assign rst_n = rst_sync_r[1];

  assign item_sel = bus_addr[CMU_ITEM_SEL_BIT];
  assign item_idx = bus_addr[CMU_ITEM_IDX_LSB +: CMU_IDX_W];
  assign field = bus_addr[CMU_FIELD_LSB +: CMU_FIELD_W];
  assign status_rd = bus_rd && !item_sel && bus_addr == CMU_ADDR_STATUS;
  assign mask_wr = bus_wr && !item_sel && bus_addr == CMU_ADDR_MASK;

  // counts above sixteen are clamped so every item stays reachable
  always_comb
  begin
    active_nxt = bus_wdata[CMU_CTRL_ACT_LSB +: CMU_ACT_W];
    if (active_nxt > CMU_ACTIVE_MAX)
      active_nxt = CMU_ACTIVE_MAX;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= CMU_MODE_TARGET;
      enable_r <= 1'h0;
      active_r <= CMU_ACTIVE_RST;
    end
    else if (bus_wr && !item_sel && bus_addr == CMU_ADDR_CTRL)
    begin
      mode_r <= cmu_mode_t'(bus_wdata[CMU_CTRL_MODE_BIT]);
      enable_r <= bus_wdata[CMU_CTRL_EN_BIT];
      active_r <= active_nxt;
    end
  end

  // each item word is written on its own, no item touches another
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CMU_ITEMS; i++)
        cfg_r[i] <= '0;
    end
    else if (bus_wr && item_sel)
    begin
      unique case (field)
        CMU_FLD_LOW:
          cfg_r[item_idx].low <= bus_wdata;
        CMU_FLD_HIGH:
          cfg_r[item_idx].high <= bus_wdata;
        CMU_FLD_UP_SET:
          cfg_r[item_idx].up_set <= bus_wdata[CMU_FLAGS-1:0];
        CMU_FLD_UP_RST:
          cfg_r[item_idx].up_rst <= bus_wdata[CMU_FLAGS-1:0];
        CMU_FLD_DN_SET:
          cfg_r[item_idx].dn_set <= bus_wdata[CMU_FLAGS-1:0];
        CMU_FLD_DN_RST:
          cfg_r[item_idx].dn_rst <= bus_wdata[CMU_FLAGS-1:0];
        default:
          ;
      endcase
    end
  end

  // all items compare at once, none waits for another
  generate
    for (genvar g = 0; g < CMU_ITEMS; g++)
    begin : g_item
      assign item_active[g] = enable_r && (g < int'(active_r));
      cmu_item u_item
      (
        .count(count),
        .cfg(cfg_r[g]),
        .mode(mode_r),
        .active(item_active[g]),
        .action(action[g])
      );
    end
  endgenerate

  // lowest index applied last so it overrides the others
  always_comb
  begin
    merged = flags_r;
    for (int i = CMU_ITEMS - 1; i >= 0; i--)
      merged = (merged | action[i].set) & ~action[i].clr;
  end

  // a match that changes the flags on the same edge as a software write to the flags wins
  always_comb
  begin
    flags_nxt = merged;
    if (bus_wr && !item_sel && bus_addr == CMU_ADDR_FLAGS && merged == flags_r)
      flags_nxt = bus_wdata[CMU_FLAGS-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_r <= CMU_FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  assign rise = flags_nxt & ~flags_r;

  cmu_irq u_irq
  (
    .clk(clk),
    .rst_n(rst_n),
    .events(rise),
    .status_rd(status_rd),
    .mask_wr(mask_wr),
    .mask_wdata(bus_wdata[CMU_FLAGS-1:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  always_comb
  begin
    rdata_nxt = CMU_DATA_ZERO;
    if (item_sel)
    begin
      unique case (field)
        CMU_FLD_LOW:
          rdata_nxt = cfg_r[item_idx].low;
        CMU_FLD_HIGH:
          rdata_nxt = cfg_r[item_idx].high;
        CMU_FLD_UP_SET:
          rdata_nxt[CMU_FLAGS-1:0] = cfg_r[item_idx].up_set;
        CMU_FLD_UP_RST:
          rdata_nxt[CMU_FLAGS-1:0] = cfg_r[item_idx].up_rst;
        CMU_FLD_DN_SET:
          rdata_nxt[CMU_FLAGS-1:0] = cfg_r[item_idx].dn_set;
        CMU_FLD_DN_RST:
          rdata_nxt[CMU_FLAGS-1:0] = cfg_r[item_idx].dn_rst;
        default:
          rdata_nxt = CMU_DATA_ZERO;
      endcase
    end
    else
    begin
      unique case (bus_addr)
        CMU_ADDR_CTRL:
        begin
          rdata_nxt[CMU_CTRL_MODE_BIT] = mode_r;
          rdata_nxt[CMU_CTRL_EN_BIT] = enable_r;
          rdata_nxt[CMU_CTRL_ACT_LSB +: CMU_ACT_W] = active_r;
        end
        CMU_ADDR_FLAGS:
          rdata_nxt[CMU_FLAGS-1:0] = flags_r;
        CMU_ADDR_STATUS:
          rdata_nxt[CMU_FLAGS-1:0] = status;
        CMU_ADDR_MASK:
          rdata_nxt[CMU_FLAGS-1:0] = mask;
        default:
          rdata_nxt = CMU_DATA_ZERO;
      endcase
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= CMU_DATA_ZERO;
    else if (bus_rd)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= CMU_DATA_ZERO;
  end

  assign bus_rdata = rdata_r;
  assign match_flags = flags_r;
endmodule : cmu_unit

/* File: test/cmu_unit_assertions.sv */
/*
  Port checker for cmu_unit, bound to every instance.
  Assumes bus strobes never overlap and config is only changed by the bus.
*/
`timescale 1ns/1ps
module cmu_unit_assertions
  import cmu_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire cmu_count_t count,
  input wire logic [CMU_ADDR_W-1:0] bus_addr,
  input wire logic [CMU_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [CMU_DATA_W-1:0] bus_rdata,
  input wire logic [CMU_FLAGS-1:0] match_flags,
  input wire logic irq
);
  logic [1:0] ctrl_r;
  logic [CMU_FLAGS-1:0] mask_r;
  logic fl_wr;
  assign fl_wr = bus_wr && bus_addr == CMU_ADDR_FLAGS;
  // shadow of mode, enable and mask, kept from bus writes only
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r <= 2'h0;
      mask_r <= 16'h0000;
    end
    else if (bus_wr)
    begin
      if (bus_addr == CMU_ADDR_CTRL)
        ctrl_r <= bus_wdata[1:0];
      if (bus_addr == CMU_ADDR_MASK)
        mask_r <= bus_wdata[15:0];
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_read_flags: assert property ($past(bus_rd && bus_addr == CMU_ADDR_FLAGS)
    |-> bus_rdata == {16'h0000, $past(match_flags)})
    else $error("flag readback wrong");
  a_read_mask: assert property ($past(bus_rd && bus_addr == CMU_ADDR_MASK)
    |-> bus_rdata == {16'h0000, $past(mask_r)})
    else $error("mask readback wrong");
  a_read_mode: assert property ($past(bus_rd && bus_addr == CMU_ADDR_CTRL)
    |-> bus_rdata[1:0] == $past(ctrl_r))
    else $error("mode readback wrong");
  a_flag_preset: assert property (fl_wr && !count.step && ctrl_r != 2'h3
    |=> match_flags == $past(bus_wdata[15:0]))
    else $error("flag preset lost");
  a_step_only: assert property ($changed(match_flags) && $past(ctrl_r) != 2'h3
    |-> $past(count.step && ctrl_r[1] || fl_wr))
    else $error("flags moved without a step");
  a_irq_rise: assert property (|(match_flags & ~$past(match_flags) & mask_r) |-> irq)
    else $error("irq missing on flag rise");
  a_irq_masked: assert property (mask_r == 16'h0000 |-> !irq)
    else $error("irq with all masked");
  a_irq_hold: assert property (irq && !bus_wr && !(bus_rd && bus_addr == CMU_ADDR_STATUS) |=> irq)
    else $error("irq dropped without status read");
  c_target_hit: cover property (count.step && ctrl_r == 2'h2 ##1 $changed(match_flags));
  c_band_hit: cover property (ctrl_r == 2'h3 ##1 $changed(match_flags));
  c_irq: cover property ($rose(irq));
endmodule : cmu_unit_assertions

bind cmu_unit cmu_unit_assertions u_cmu_unit_assertions (.clk(clk), .reset_n(reset_n),
  .count(count), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .match_flags(match_flags), .irq(irq));

/* File: test/cmu_unit_test.sv */
/*
  Self-checking bench for cmu_unit: registers, target and band matching, irq.
  Assumes a 10 MHz clock and the register map of cmu_pkg.
*/
`timescale 1ns/1ps
module cmu_unit_test
  import cmu_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  cmu_count_t count = '0;
  logic [CMU_ADDR_W-1:0] bus_addr = '0;
  logic [CMU_DATA_W-1:0] bus_wdata = '0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [CMU_DATA_W-1:0] bus_rdata;
  logic [CMU_FLAGS-1:0] match_flags;
  logic irq;
  int bad_count = 0;
  int compares = 0;
  always #50 clk = ~clk;
  cmu_unit u_cmu_unit (.clk(clk), .reset_n(reset_n), .count(count), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .match_flags(match_flags), .irq(irq));
  function automatic logic [9:0] ia(input logic [3:0] i, input logic [2:0] f);
    return {1'b1, i, f, 2'b00};
  endfunction : ia
  task summarize;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  // every driver starts on a fresh edge, so back to back calls never clash
  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr
  task rd(input string name, input logic [9:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    cmp(name, exp, bus_rdata);
  endtask : rd
  task step(input logic up, input logic [31:0] v);
    @(posedge clk);
    count <= {1'b1, up, v};
    @(posedge clk);
    count.step <= 1'b0;
  endtask : step
  task chk(input logic [15:0] exp, input logic irq_exp);
    @(negedge clk);
    cmp("flags", {16'h0000, exp}, {16'h0000, match_flags});
    cmp("irq", {31'h0000_0000, irq_exp}, {31'h0000_0000, irq});
  endtask : chk
  task t_reset;
    rd("ctrl", CMU_ADDR_CTRL, 32'h0000_1000);
    rd("flags", CMU_ADDR_FLAGS, 32'h0000_0000);
    rd("unmapped", 10'h100, 32'h0000_0000);
    wr(CMU_ADDR_CTRL, 32'h0000_1F00);
    rd("clamp", CMU_ADDR_CTRL, 32'h0000_1000);
    wr(ia(4'hF, CMU_FLD_LOW), 32'h0000_1234);
    rd("item15", ia(4'hF, CMU_FLD_LOW), 32'h0000_1234);
  endtask : t_reset
  task t_target;
    wr(ia(4'h0, CMU_FLD_LOW), 32'h0000_01F4);
    wr(ia(4'h0, CMU_FLD_UP_SET), 32'h0000_0002);
    wr(ia(4'h0, CMU_FLD_DN_SET), 32'h0000_0004);
    wr(ia(4'h0, CMU_FLD_DN_RST), 32'h0000_0002);
    wr(ia(4'h1, CMU_FLD_LOW), 32'h0000_01F4);
    wr(ia(4'h1, CMU_FLD_UP_RST), 32'h0000_0003);
    wr(ia(4'h1, CMU_FLD_DN_SET), 32'h0000_0001);
    wr(ia(4'h1, CMU_FLD_DN_RST), 32'h0000_0004);
    wr(CMU_ADDR_MASK, 32'h0000_0006);
    wr(CMU_ADDR_CTRL, 32'h0000_1002);
    step(1'b1, 32'h0000_01F4);
    chk(16'h0002, 1'b1);
    rd("status", CMU_ADDR_STATUS, 32'h0000_0002);
    chk(16'h0002, 1'b0);
    step(1'b0, 32'h0000_01F4);
    chk(16'h0005, 1'b1);
    rd("status", CMU_ADDR_STATUS, 32'h0000_0005);
    step(1'b1, 32'h0000_01F5);
    chk(16'h0005, 1'b0);
    // item 1 drops out of the active set
    wr(CMU_ADDR_CTRL, 32'h0000_0102);
    rd("ctrl", CMU_ADDR_CTRL, 32'h0000_0102);
    step(1'b1, 32'h0000_01F4);
    chk(16'h0007, 1'b1);
    wr(CMU_ADDR_FLAGS, 32'h0000_0000);
    rd("status", CMU_ADDR_STATUS, 32'h0000_0002);
    chk(16'h0000, 1'b0);
  endtask : t_target
  task t_band;
    wr(ia(4'h0, CMU_FLD_LOW), 32'hFFFF_FFF6);
    wr(ia(4'h0, CMU_FLD_HIGH), 32'h0000_000A);
    wr(ia(4'h0, CMU_FLD_UP_SET), 32'h0000_0000);
    wr(ia(4'h0, CMU_FLD_UP_RST), 32'h0000_0010);
    wr(ia(4'h1, CMU_FLD_LOW), 32'h0000_0064);
    wr(ia(4'h1, CMU_FLD_HIGH), 32'hFFFF_FF9C);
    wr(ia(4'h1, CMU_FLD_UP_SET), 32'h0000_0010);
    wr(ia(4'h1, CMU_FLD_UP_RST), 32'h0000_0000);
    wr(CMU_ADDR_CTRL, 32'h0000_0203);
    step(1'b1, 32'h0000_00C8);
    chk(16'h0010, 1'b0);
    step(1'b0, 32'h0000_0000);
    chk(16'h0000, 1'b0);
    step(1'b0, 32'hFFFF_FF38);
    chk(16'h0010, 1'b0);
    step(1'b1, 32'h0000_0032);
    chk(16'h0010, 1'b0);
  endtask : t_band
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_target;
    t_band;
    summarize;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize;
  end
endmodule : cmu_unit_test
